/* File: core/smart_card_interface_control.sv */
// Smart-card interface control: presence debounce, activation sequencer,
// card clock divider, reset and supply selection, line translation, interrupt.
// Assumes all pin inputs are synchronous to CLOCK and an APB master on the bus.
//
// What this block does
// - Supply selects decode to 5 V, 3 V or 1.8 V card supply.
// - Low-active card detect reports a card while held low.
// - Insertion is accepted only after about 8 ms of stable presence.
// - Larger variant also accepts a high-active card detect input.
// - Card clock comes from the external clock through the divider.
// - External clock divided by 1, 2, 4 or 8 per two select inputs.
// - Card reset follows the host reset input while the card is active; it is held low otherwise.
// - Interrupt signals presence changes and faults.
// - Overcurrent, overtemperature, removal or undervoltage deactivate the card.
// - Data line passes both ways and idles high through a pull-up.
// - Larger variant passes two auxiliary lines the same way.
// - Activation starts on a high-to-low command edge with a card present.
// - Interrupt output is active low.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/10ps

module smart_card_interface_control #(
  parameter int unsigned DEBOUNCE_CYCLES = smart_card_pkg::DEBOUNCE_CYCLES,
  parameter bit          LARGE_PACKAGE   = 1'b1,
  parameter logic [1:0]  DIV_SHIFT_SEL0  = 2'h0,
  parameter logic [1:0]  DIV_SHIFT_SEL1  = 2'h1,
  parameter logic [1:0]  DIV_SHIFT_SEL2  = 2'h2,
  parameter logic [1:0]  DIV_SHIFT_SEL3  = 2'h3
) (
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SUPPLY_MODE_SELECT,
  input  wire logic        SUPPLY_LEVEL_SELECT,
  input  wire logic        CARD_DETECT_IN_N,
  input  wire logic        CARD_DETECT_HIGH_IN,
  input  wire logic        EXT_CLOCK_IN,
  input  wire logic        DIV_SELECT_A,
  input  wire logic        DIV_SELECT_B,
  input  wire logic        HOST_RESET_IN,
  input  wire logic        ACTIVATION_COMMAND_N,
  input  wire logic        OVERCURRENT_FAULT,
  input  wire logic        OVERTEMP_FAULT,
  input  wire logic        UNDERVOLTAGE_FAULT,
  output logic             CARD_SUPPLY_EN,
  output logic      [1:0]  CARD_SUPPLY_LEVEL,
  output logic             CARD_CLOCK_OUT,
  output logic             CARD_RESET_OUT,
  output logic             INT_N,
  input  wire logic [2:0]  CARD_LINE_IN,
  output logic      [2:0]  CARD_LINE_OUT,
  output logic      [2:0]  CARD_LINE_OE,
  input  wire logic [2:0]  HOST_LINE_IN,
  output logic      [2:0]  HOST_LINE_OUT,
  output logic      [2:0]  HOST_LINE_OE
);

  // ==========================================================================
  // Functions
  // ==========================================================================
  function automatic smart_card_pkg::supply_t supply_decode(input logic mode,
                                                            input logic level);
    if (!mode) begin
      supply_decode = level ? smart_card_pkg::SUPPLY_5V : smart_card_pkg::SUPPLY_3V;
    end else begin
      supply_decode = level ? smart_card_pkg::SUPPLY_1V8 : smart_card_pkg::SUPPLY_3V;
    end
  endfunction

  function automatic logic clock_tap(input logic [2:0] cnt, input logic [1:0] shift,
                                     input logic raw);
    case (shift)
      2'h0:    clock_tap = raw;
      2'h1:    clock_tap = cnt[0];
      2'h2:    clock_tap = cnt[1];
      default: clock_tap = cnt[2];
    endcase
  endfunction

  // ==========================================================================
  // Declarations
  // ==========================================================================
  localparam logic [smart_card_pkg::DEBOUNCE_W-1:0] DEB_LAST =
    smart_card_pkg::DEBOUNCE_W'(DEBOUNCE_CYCLES - 1);

  smart_card_pkg::seq_state_t  state;
  smart_card_pkg::seq_state_t  next_state;
  smart_card_pkg::line_owner_t owner [smart_card_pkg::LINE_COUNT];

  logic [smart_card_pkg::DEBOUNCE_W-1:0] deb_cnt;
  logic [smart_card_pkg::EV_W-1:0]       irq_status;
  logic [smart_card_pkg::EV_W-1:0]       irq_enable;
  logic [2:0]                            div_cnt;
  logic                                  present;
  logic                                  present_prev;
  logic                                  cmd_prev;
  logic                                  ext_prev;

  // ==========================================================================
  // Card presence and debounce
  // ==========================================================================
  wire raw_present = !CARD_DETECT_IN_N
                   || (LARGE_PACKAGE && CARD_DETECT_HIGH_IN);
  wire deb_done    = (deb_cnt == DEB_LAST);

  // Removal is taken at once so a pulled card is deactivated without delay;
  // only insertion waits out contact bounce.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      deb_cnt <= '0;
      present <= 1'b0;
      present_prev <= 1'b0;
    end else begin
      if (!raw_present || present) begin
        deb_cnt <= '0;
      end else if (!deb_done) begin
        deb_cnt <= deb_cnt + 1'b1;
      end
      present <= raw_present && (present || deb_done);
      present_prev <= present;
    end
  end

  // ==========================================================================
  // Activation sequencer
  // ==========================================================================
  wire any_fault = OVERCURRENT_FAULT || OVERTEMP_FAULT || UNDERVOLTAGE_FAULT;
  wire cmd_fall  = cmd_prev && !ACTIVATION_COMMAND_N;
  wire start     = cmd_fall && present && !any_fault;
  wire stop      = any_fault || !present || ACTIVATION_COMMAND_N;
  wire active    = (state == smart_card_pkg::SEQ_ACTIVE);

  always_comb begin
    case (state)
      smart_card_pkg::SEQ_IDLE:
        next_state = start ? smart_card_pkg::SEQ_ACTIVE : smart_card_pkg::SEQ_IDLE;
      smart_card_pkg::SEQ_ACTIVE:
        next_state = stop ? smart_card_pkg::SEQ_DEACT : smart_card_pkg::SEQ_ACTIVE;
      smart_card_pkg::SEQ_DEACT:
        next_state = smart_card_pkg::SEQ_IDLE;
      default:
        next_state = smart_card_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state    <= smart_card_pkg::SEQ_IDLE;
      cmd_prev <= 1'b1;
    end else begin
      state    <= next_state;
      cmd_prev <= ACTIVATION_COMMAND_N;
    end
  end

  // ==========================================================================
  // Card supply, reset and clock
  // ==========================================================================
  wire [1:0] div_code  = {DIV_SELECT_B, DIV_SELECT_A};
  wire [1:0] div_shift = (div_code == 2'h0) ? DIV_SHIFT_SEL0 :
                         (div_code == 2'h1) ? DIV_SHIFT_SEL1 :
                         (div_code == 2'h2) ? DIV_SHIFT_SEL2 : DIV_SHIFT_SEL3;
  wire       ext_rise  = EXT_CLOCK_IN && !ext_prev;
  wire       next_card_clock = active && clock_tap(div_cnt, div_shift, EXT_CLOCK_IN);
  wire [1:0] next_supply = active ? supply_decode(SUPPLY_MODE_SELECT, SUPPLY_LEVEL_SELECT)
                                  : smart_card_pkg::SUPPLY_OFF;

  // The external clock is sampled by CLOCK, so each input half period must
  // span at least one CLOCK period; faster inputs alias.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ext_prev          <= 1'b0;
      div_cnt           <= '0;
      CARD_CLOCK_OUT    <= 1'b0;
      CARD_RESET_OUT    <= 1'b0;
      CARD_SUPPLY_EN    <= 1'b0;
      CARD_SUPPLY_LEVEL <= smart_card_pkg::SUPPLY_OFF;
    end else begin
      ext_prev          <= EXT_CLOCK_IN;
      div_cnt           <= ext_rise ? div_cnt + 1'b1 : div_cnt;
      CARD_CLOCK_OUT    <= next_card_clock;
      CARD_RESET_OUT    <= active && HOST_RESET_IN;
      CARD_SUPPLY_EN    <= active;
      CARD_SUPPLY_LEVEL <= next_supply;
    end
  end

  // ==========================================================================
  // Card line translation
  // ==========================================================================
  // Whichever side pulls a line low first owns it until it lets go, so the
  // repeated low on the other side cannot latch the line low forever.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < smart_card_pkg::LINE_COUNT; i++) begin
        owner[i] <= smart_card_pkg::OWNER_NONE;
      end
    end else begin
      for (int i = 0; i < smart_card_pkg::LINE_COUNT; i++) begin
        if (!active || (i > 0 && !LARGE_PACKAGE)) begin
          owner[i] <= smart_card_pkg::OWNER_NONE;
        end else if (owner[i] == smart_card_pkg::OWNER_NONE) begin
          if (!HOST_LINE_IN[i]) begin
            owner[i] <= smart_card_pkg::OWNER_HOST;
          end else if (!CARD_LINE_IN[i]) begin
            owner[i] <= smart_card_pkg::OWNER_CARD;
          end
        end else if (owner[i] == smart_card_pkg::OWNER_HOST && HOST_LINE_IN[i]) begin
          owner[i] <= smart_card_pkg::OWNER_NONE;
        end else if (owner[i] == smart_card_pkg::OWNER_CARD && CARD_LINE_IN[i]) begin
          owner[i] <= smart_card_pkg::OWNER_NONE;
        end
      end
    end
  end

  // Lines only ever pull low; the high level comes from the pull-ups.
  // While the card is off its contacts are held low.
  assign CARD_LINE_OUT = 3'h0;
  assign HOST_LINE_OUT = 3'h0;
  always_comb begin
    for (int i = 0; i < smart_card_pkg::LINE_COUNT; i++) begin
      CARD_LINE_OE[i] = !active || (owner[i] == smart_card_pkg::OWNER_HOST);
      HOST_LINE_OE[i] = (owner[i] == smart_card_pkg::OWNER_CARD);
    end
  end

  // ==========================================================================
  // Interrupt registers and APB slave
  // ==========================================================================
  wire [smart_card_pkg::EV_W-1:0] events = {
    active && stop,
    UNDERVOLTAGE_FAULT,
    OVERTEMP_FAULT,
    OVERCURRENT_FAULT,
    present != present_prev
  };
  wire bus_wr    = PSEL && PENABLE && PWRITE;
  wire bus_setup = PSEL && !PENABLE;
  wire sel_stat  = (PADDR == smart_card_pkg::IRQ_STATUS_OFFSET);
  wire sel_en    = (PADDR == smart_card_pkg::IRQ_ENABLE_OFFSET);
  wire sel_clr   = (PADDR == smart_card_pkg::IRQ_CLEAR_OFFSET);
  wire sel_state = (PADDR == smart_card_pkg::STATE_OFFSET);
  wire mapped    = sel_stat || sel_en || sel_clr || sel_state;
  wire [smart_card_pkg::EV_W-1:0] clr_mask =
    (bus_wr && sel_clr) ? PWDATA[smart_card_pkg::EV_W-1:0] : '0;
  wire [31:0] state_word = {24'h0, 1'b0, div_shift, CARD_SUPPLY_LEVEL, state, present};
  wire [31:0] read_word  = sel_stat  ? {27'h0, irq_status} :
                           sel_en    ? {27'h0, irq_enable} :
                           sel_state ? state_word : 32'h0;

  // A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      irq_status <= '0;
      irq_enable <= smart_card_pkg::IRQ_ENABLE_RESET;
      PRDATA     <= 32'h0;
    end else begin
      irq_status <= (irq_status & ~clr_mask) | events;
      if (bus_wr && sel_en) begin
        irq_enable <= PWDATA[smart_card_pkg::EV_W-1:0];
      end
      if (bus_setup) begin
        PRDATA <= PWRITE ? 32'h0 : read_word;
      end
    end
  end

  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign INT_N   = !(|(irq_status & irq_enable));

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  a_supply_decode: assert property (active |=> CARD_SUPPLY_LEVEL ==
      $past(supply_decode(SUPPLY_MODE_SELECT, SUPPLY_LEVEL_SELECT)))
    else $error("Card supply level does not match the selects.");

  a_present_low: assert property (present |-> $past(raw_present))
    else $error("Card reported present without an active detect input.");

  a_debounce_wait: assert property ($rose(present) |-> $past(deb_done))
    else $error("Card accepted before the debounce interval ran out.");

  a_clock_idle: assert property (!active |=> !CARD_CLOCK_OUT)
    else $error("Card clock runs while the card is inactive.");

  a_divide_one: assert property (
      active && div_shift == 2'h0 |=> CARD_CLOCK_OUT == $past(EXT_CLOCK_IN))
    else $error("Divide-by-one clock does not follow the input.");

  a_reset_follow: assert property (
      active |=> CARD_RESET_OUT == $past(HOST_RESET_IN))
    else $error("Card reset does not follow host reset.");

  a_fault_deact: assert property (
      active && any_fault |=> state == smart_card_pkg::SEQ_DEACT
      ##1 state == smart_card_pkg::SEQ_IDLE)
    else $error("Fault did not deactivate the card.");

  a_presence_irq: assert property (
      present != $past(present) && irq_enable[smart_card_pkg::EV_PRESENCE]
      |=> !INT_N [*2])
    else $error("Presence change did not pull the interrupt low.");

  a_start_card: assert property (
      state == smart_card_pkg::SEQ_ACTIVE && $past(state) == smart_card_pkg::SEQ_IDLE
      |-> $past(present) && $past(cmd_prev) && !$past(ACTIVATION_COMMAND_N))
    else $error("Activation began without a command edge and a card.");

  a_line_follow: assert property (
      active && owner[1] == smart_card_pkg::OWNER_NONE && !HOST_LINE_IN[1]
      && LARGE_PACKAGE ##1 active |-> CARD_LINE_OE[1])
    else $error("Host low on an auxiliary line was not passed to the card.");

  a_supply_off: assert property (
      !active |=> !CARD_SUPPLY_EN && CARD_SUPPLY_LEVEL == smart_card_pkg::SUPPLY_OFF)
    else $error("Card supply stays on while the card is inactive.");

  a_removal_deact: assert property (
      active && !present |=> state == smart_card_pkg::SEQ_DEACT)
    else $error("Card removal did not deactivate the card.");

  a_fault_irq: assert property (
      OVERCURRENT_FAULT && irq_enable[smart_card_pkg::EV_OVERCURR] && !(bus_wr && sel_en)
      |=> !INT_N)
    else $error("Overcurrent did not pull the interrupt low.");

  a_line_release: assert property (
      owner[0] == smart_card_pkg::OWNER_HOST && HOST_LINE_IN[0] |=> CARD_LINE_OE[0] == !active)
    else $error("Host release of the data line was not passed to the card.");

endmodule // smart_card_interface_control

/* File: shared/smart_card_pkg.sv */
// Constants, register map and types of the smart-card interface control block.
// Assumes a 50 MHz system clock and an APB register bus with 32-bit data.
package smart_card_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLOCK_HZ        = 50_000_000;
  localparam int unsigned DEBOUNCE_US     = 8_000;
  localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_US * (CLOCK_HZ / 1_000_000);
  localparam int unsigned DEBOUNCE_W      = 19;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h04;
  localparam logic [7:0] IRQ_CLEAR_OFFSET  = 8'h08;
  localparam logic [7:0] STATE_OFFSET      = 8'h0C;

  // Event bit positions, shared by status, enable and clear.
  localparam int unsigned EV_PRESENCE   = 0;
  localparam int unsigned EV_OVERCURR   = 1;
  localparam int unsigned EV_OVERTEMP   = 2;
  localparam int unsigned EV_UNDERVOLT  = 3;
  localparam int unsigned EV_DEACTIVATE = 4;
  localparam int unsigned EV_W          = 5;
  localparam logic [4:0]  IRQ_ENABLE_RESET = 5'h1F;

  // State register fields.
  localparam int unsigned ST_PRESENT_BIT = 0;
  localparam int unsigned ST_SEQ_LSB     = 1;
  localparam int unsigned ST_SUPPLY_LSB  = 3;
  localparam int unsigned ST_DIV_LSB     = 5;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'h0,
    SEQ_ACTIVE = 2'h1,
    SEQ_DEACT  = 2'h3
  } seq_state_t;

  typedef enum logic [1:0] {
    SUPPLY_OFF = 2'h0,
    SUPPLY_3V  = 2'h1,
    SUPPLY_5V  = 2'h2,
    SUPPLY_1V8 = 2'h3
  } supply_t;

  typedef enum logic [1:0] {
    OWNER_NONE = 2'h0,
    OWNER_HOST = 2'h1,
    OWNER_CARD = 2'h2
  } line_owner_t;

  localparam int unsigned LINE_COUNT = 3;

endpackage

/* File: testbench/card_model.sv */
// Card-side model of the data and auxiliary lines behind the control block.
// Assumes the block pulls a line low while its enable bit is high.
`timescale 1ns/10ps

module card_model (
  input  wire logic [2:0] line_oe,
  input  wire logic [2:0] card_pull,
  output logic      [2:0] line_in
);
  // A released line is never left floating: the pull-up wins unless a party pulls low.
  assign line_in = ~(line_oe | card_pull);
endmodule  // card_model

/* File: testbench/tb_smart_card_interface_control.sv */
// Self-checking bench of the smart-card interface control block.
// Assumes the bench plays the host and card_model the card lines.
`timescale 1ns/10ps

module tb_smart_card_interface_control;
  logic        clock = 1'b0, rstn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, e;
  logic        vmode = 1'b0, vlevel = 1'b0, det_n = 1'b1, det_h = 1'b0;
  logic        ext = 1'b0, div_a = 1'b0, div_b = 1'b0, hr = 1'b0, cmd_n = 1'b1;
  logic [2:0]  flt = 3'h0, card_pull = 3'h0, host_pull = 3'h0;
  logic [2:0]  card_in, card_oe, host_oe, host_in, card_out, host_out;
  logic        sup_en, card_clk, card_rst, int_n, prev;
  logic [1:0]  sup_lvl;
  int          err_count = 0, n_compared = 0, cnt;

  always #10 clock = ~clock;
  assign host_in = ~(host_oe | host_pull);

  smart_card_interface_control #(.DEBOUNCE_CYCLES(16)) u_smart_card_interface_control (
    .CLOCK(clock), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SUPPLY_MODE_SELECT(vmode), .SUPPLY_LEVEL_SELECT(vlevel), .CARD_DETECT_IN_N(det_n),
    .CARD_DETECT_HIGH_IN(det_h), .EXT_CLOCK_IN(ext), .DIV_SELECT_A(div_a),
    .DIV_SELECT_B(div_b), .HOST_RESET_IN(hr), .ACTIVATION_COMMAND_N(cmd_n),
    .OVERCURRENT_FAULT(flt[0]), .OVERTEMP_FAULT(flt[1]), .UNDERVOLTAGE_FAULT(flt[2]),
    .CARD_SUPPLY_EN(sup_en), .CARD_SUPPLY_LEVEL(sup_lvl), .CARD_CLOCK_OUT(card_clk),
    .CARD_RESET_OUT(card_rst), .INT_N(int_n), .CARD_LINE_IN(card_in),
    .CARD_LINE_OUT(card_out), .CARD_LINE_OE(card_oe), .HOST_LINE_IN(host_in),
    .HOST_LINE_OUT(host_out), .HOST_LINE_OE(host_oe));

  card_model u_card_model (.line_oe(card_oe), .card_pull(card_pull), .line_in(card_in));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 50) begin
      err_count++;
      $display("[FAIL] pready expected 1 seen %b", pready);
      test_done();
    end
  endtask

  // Outputs are looked at on the falling edge, where they have settled.
  task automatic look(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic activate;
    @(posedge clock); cmd_n <= 1'b1;
    @(posedge clock); cmd_n <= 1'b0;
    look(4);
  endtask

  task automatic deactivate;
    @(posedge clock); cmd_n <= 1'b1;
    look(4);
  endtask

  function automatic logic [1:0] exp_supply(input logic m, input logic l);
    if (!m) return l ? smart_card_pkg::SUPPLY_5V : smart_card_pkg::SUPPLY_3V;
    return l ? smart_card_pkg::SUPPLY_1V8 : smart_card_pkg::SUPPLY_3V;
  endfunction

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    void'($urandom(32'h02AF));
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    apb(1'b0, smart_card_pkg::IRQ_ENABLE_OFFSET, 32'h0);
    chk("irq enable reset", 32'h1F, q);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    activate();
    chk("no card no supply", 32'h0, {31'h0, sup_en});
    $display("test reset done");

    @(posedge clock); det_n <= 1'b0;
    look(6);
    apb(1'b0, smart_card_pkg::STATE_OFFSET, 32'h0);
    chk("present early", 32'h0, {31'h0, q[0]});
    look(20);
    apb(1'b0, smart_card_pkg::STATE_OFFSET, 32'h0);
    chk("present late", 32'h1, {31'h0, q[0]});
    apb(1'b0, smart_card_pkg::IRQ_STATUS_OFFSET, 32'h0);
    chk("presence event", 32'h1, {31'h0, q[0]});
    chk("int asserted", 32'h0, {31'h0, int_n});
    apb(1'b1, smart_card_pkg::IRQ_ENABLE_OFFSET, 32'h0);
    look(1);
    chk("int masked", 32'h1, {31'h0, int_n});
    apb(1'b1, smart_card_pkg::IRQ_ENABLE_OFFSET, 32'h1F);
    apb(1'b1, smart_card_pkg::IRQ_CLEAR_OFFSET, 32'h1F);
    look(1);
    chk("int cleared", 32'h1, {31'h0, int_n});
    $display("test presence done");

    for (int i = 0; i < 4; i++) begin
      @(posedge clock); vmode <= i[1]; vlevel <= i[0];
      activate();
      chk("supply on", 32'h1, {31'h0, sup_en});
      chk("supply level", {30'h0, exp_supply(i[1], i[0])}, {30'h0, sup_lvl});
      @(posedge clock); hr <= 1'($urandom);
      look(3);
      chk("card reset", {31'h0, hr}, {31'h0, card_rst});
      deactivate();
      chk("supply off", 32'h0, {31'h0, sup_en});
    end
    $display("test supply done");

    activate();
    for (int c = 0; c < 4; c++) begin
      @(posedge clock); div_a <= c[0]; div_b <= c[1];
      look(2);
      cnt = 0;
      prev = card_clk;
      repeat (64) begin
        @(posedge clock); ext <= ~ext;
        @(negedge clock);
        if (card_clk && !prev) cnt++;
        prev = card_clk;
      end
      chk("clock edges", 32 >> c, (cnt >= (32 >> c) - 1 && cnt <= (32 >> c) + 1) ? 32 >> c : cnt);
      apb(1'b0, smart_card_pkg::STATE_OFFSET, 32'h0);
      chk("divider shift", c, {30'h0, q[6:5]});
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge clock); card_pull <= 3'h1 << i;
      look(3);
      chk("host pulled", 32'h1 << i, {29'h0, host_oe});
      chk("line out low", 32'h0, {26'h0, card_out, host_out});
      @(posedge clock); card_pull <= 3'h0;
      look(3);
      chk("host released", 32'h0, {29'h0, host_oe});
      @(posedge clock); host_pull <= 3'h1 << i;
      look(3);
      chk("card pulled", 32'h1 << i, {29'h0, card_oe});
      @(posedge clock); host_pull <= 3'h0;
      look(3);
      chk("card released", 32'h0, {29'h0, card_oe});
    end
    deactivate();
    $display("test clock and lines done");

    apb(1'b1, smart_card_pkg::IRQ_CLEAR_OFFSET, 32'h1F);
    for (int f = 0; f < 3; f++) begin
      activate();
      @(posedge clock); flt <= 3'h1 << f;
      look(4);
      chk("fault off", 32'h0, {31'h0, sup_en});
      @(posedge clock); flt <= 3'h0;
      apb(1'b0, smart_card_pkg::IRQ_STATUS_OFFSET, 32'h0);
      chk("fault event", 32'h12 << f & 32'h1E | 32'h10, q & (32'h12 << f | 32'h10));
      chk("fault int", 32'h0, {31'h0, int_n});
      apb(1'b1, smart_card_pkg::IRQ_CLEAR_OFFSET, 32'h1F);
    end
    activate();
    @(posedge clock); det_n <= 1'b1;
    look(4);
    chk("removal off", 32'h0, {31'h0, sup_en});
    apb(1'b0, smart_card_pkg::IRQ_STATUS_OFFSET, 32'h0);
    chk("removal event", 32'h11, q & 32'h11);
    @(posedge clock); det_h <= 1'b1;
    look(30);
    apb(1'b0, smart_card_pkg::STATE_OFFSET, 32'h0);
    chk("high detect", 32'h1, {31'h0, q[0]});
    $display("test faults done");
    test_done();
  end
endmodule  // tb_smart_card_interface_control
